// ### common/uart_resp_pkg.sv
package uart_resp_pkg;

    localparam int unsigned CLK_HZ       = 20000000;
    localparam int unsigned BAUD_BPS     = 9600;
    localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD_BPS;
    localparam logic [11:0] BIT_CNT      = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] HALF_CNT     = 12'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0]  FRAME_LAST   = 4'ha;

    localparam int unsigned RING_DEPTH   = 16;
    localparam logic [7:0]  RING_FULL    = 8'h10;
    localparam logic [2:0]  REPLY_LEN    = 3'h4;

    localparam logic [2:0]  CODE_UPPER_T = 3'h0;
    localparam logic [2:0]  CODE_LOWER_T = 3'h1;
    localparam logic [2:0]  CODE_OTHER   = 3'h2;
    localparam logic [2:0]  CODE_PARITY  = 3'h3;
    localparam logic [2:0]  CODE_FRAMING = 3'h4;
    localparam logic [2:0]  CODE_OVERRUN = 3'h5;

    localparam logic [7:0]  CHAR_UPPER_T = 8'h54;
    localparam logic [7:0]  CHAR_LOWER_T = 8'h74;
    localparam logic [7:0]  BYTE_UPPER_O = 8'h4f;
    localparam logic [7:0]  BYTE_UPPER_K = 8'h4b;
    localparam logic [7:0]  BYTE_LOWER_O = 8'h6f;
    localparam logic [7:0]  BYTE_LOWER_K = 8'h6b;
    localparam logic [7:0]  BYTE_UPPER_U = 8'h55;
    localparam logic [7:0]  BYTE_UPPER_C = 8'h43;
    localparam logic [7:0]  BYTE_UPPER_P = 8'h50;
    localparam logic [7:0]  BYTE_UPPER_E = 8'h45;
    localparam logic [7:0]  BYTE_UPPER_F = 8'h46;
    localparam logic [7:0]  BYTE_CR      = 8'h0d;
    localparam logic [7:0]  BYTE_LF      = 8'h0a;

    localparam logic [3:0]  REG_CONTROL  = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_POINTERS = 4'h8;
    localparam logic [3:0]  REG_LAST     = 4'hc;
    localparam logic [1:0]  CONTROL_RST  = 2'h3;
    localparam int unsigned CTRL_RX_EN   = 0;
    localparam int unsigned CTRL_TX_EN   = 1;

endpackage

// ### hw/uart_tx_serializer.sv
`timescale 1ns/1ns
module uart_tx_serializer (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [7:0] data,
    output logic            serial_out,
    output logic            busy,
    output logic            done
);

    logic [10:0] frame;
    logic [11:0] baud_cnt;
    logic [3:0]  bit_idx;

    wire bit_end = busy && (baud_cnt == 12'h000);
    wire last    = bit_idx == uart_resp_pkg::FRAME_LAST;

    // Stop, even parity, eight data bits and start; shifted out from bit zero.
    wire [10:0] next_frame = {1'b1, ^data, data, 1'b0};

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            frame      <= 11'h7ff;
            baud_cnt   <= 12'h000;
            bit_idx    <= 4'h0;
            busy       <= 1'b0;
            done       <= 1'b0;
            serial_out <= 1'b1;
        end
        else
        begin
            done <= bit_end && last;
            if (start && !busy)
            begin
                frame      <= next_frame;
                serial_out <= 1'b0;
                baud_cnt   <= uart_resp_pkg::BIT_CNT;
                bit_idx    <= 4'h0;
                busy       <= 1'b1;
            end
            else if (bit_end)
            begin
                baud_cnt <= uart_resp_pkg::BIT_CNT;
                if (last)
                begin
                    busy       <= 1'b0;
                    serial_out <= 1'b1;
                end
                else
                begin
                    serial_out <= frame[bit_idx + 4'h1];
                    bit_idx    <= bit_idx + 4'h1;
                end
            end
            else if (busy)
            begin
                baud_cnt <= baud_cnt - 12'h001;
            end
        end
    end

endmodule

// ### hw/uart_char_responder.sv
`timescale 1ns/1ns
module uart_char_responder (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        serial_in,
    output logic             serial_out
);

    typedef enum logic [0:0] {RX_IDLE, RX_FRAME} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} tx_state_t;

    localparam int RING_SLOTS = uart_resp_pkg::RING_DEPTH;

    // Receive line synchroniser.
    logic rx_meta;
    logic rx_sync;

    // Receiver.
    rx_state_t   rx_state;
    logic [11:0] rx_baud;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_shift;
    logic        rx_par_bit;
    logic        rx_end;
    logic        rx_par_bad;
    logic        rx_stop_bad;

    // Character that completed while the ring was full and is not yet taken, and the last clean character.
    logic        hold_valid;
    logic [7:0]  hold_data;
    logic [7:0]  last_char;

    // Ring of pending reply codes.
    logic [2:0]  reply_ring [RING_SLOTS];
    logic [7:0]  ring_write_ptr;
    logic [7:0]  ring_read_ptr;
    logic [7:0]  ring_fill_count;

    // Reply transmitter control.
    tx_state_t   tx_state;
    logic [2:0]  tx_code;
    logic [2:0]  tx_remaining_count;
    logic        tx_pending;
    logic        ser_start;
    logic [7:0]  ser_data;
    logic        ser_busy;
    logic        tx_done_event;

    // Register bus.
    logic [1:0]  control;
    logic        bus_ack;

    function automatic logic [2:0] classify(input logic [7:0] ch);
        if (ch == uart_resp_pkg::CHAR_UPPER_T)
            return uart_resp_pkg::CODE_UPPER_T;
        else if (ch == uart_resp_pkg::CHAR_LOWER_T)
            return uart_resp_pkg::CODE_LOWER_T;
        else
            return uart_resp_pkg::CODE_OTHER;
    endfunction

    function automatic logic [7:0] reply_byte(input logic [2:0] code, input logic [1:0] idx);
        logic [7:0] first;
        logic [7:0] second;
        first  = uart_resp_pkg::BYTE_UPPER_U;
        second = uart_resp_pkg::BYTE_UPPER_C;
        case (code)
            uart_resp_pkg::CODE_UPPER_T:
            begin
                first  = uart_resp_pkg::BYTE_UPPER_O;
                second = uart_resp_pkg::BYTE_UPPER_K;
            end
            uart_resp_pkg::CODE_LOWER_T:
            begin
                first  = uart_resp_pkg::BYTE_LOWER_O;
                second = uart_resp_pkg::BYTE_LOWER_K;
            end
            uart_resp_pkg::CODE_PARITY:
            begin
                first  = uart_resp_pkg::BYTE_UPPER_P;
                second = uart_resp_pkg::BYTE_UPPER_E;
            end
            uart_resp_pkg::CODE_FRAMING:
            begin
                first  = uart_resp_pkg::BYTE_UPPER_F;
                second = uart_resp_pkg::BYTE_UPPER_E;
            end
            uart_resp_pkg::CODE_OVERRUN:
            begin
                first  = uart_resp_pkg::BYTE_UPPER_O;
                second = uart_resp_pkg::BYTE_UPPER_E;
            end
            default:
            begin
                first  = uart_resp_pkg::BYTE_UPPER_U;
                second = uart_resp_pkg::BYTE_UPPER_C;
            end
        endcase
        case (idx)
            2'h0:    return first;
            2'h1:    return second;
            2'h2:    return uart_resp_pkg::BYTE_CR;
            default: return uart_resp_pkg::BYTE_LF;
        endcase
    endfunction

    // Only the second stage is looked at; the idle level is high.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            rx_meta <= serial_in;
            rx_sync <= rx_meta;
        end
    end

    wire rx_enable   = control[uart_resp_pkg::CTRL_RX_EN];
    wire tx_enable   = control[uart_resp_pkg::CTRL_TX_EN];
    wire rx_tick     = (rx_state == RX_FRAME) && (rx_baud == 12'h000);
    wire rx_false    = rx_tick && (rx_idx == 4'h0) && rx_sync;
    wire rx_last_bit = rx_tick && (rx_idx == uart_resp_pkg::FRAME_LAST);

    // Sampling in the middle of each bit tolerates a few percent of rate error.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_state    <= RX_IDLE;
            rx_baud     <= 12'h000;
            rx_idx      <= 4'h0;
            rx_shift    <= 8'h00;
            rx_par_bit  <= 1'b0;
            rx_end      <= 1'b0;
            rx_par_bad  <= 1'b0;
            rx_stop_bad <= 1'b0;
        end
        else
        begin
            rx_end <= rx_last_bit;
            case (rx_state)
                RX_IDLE:
                begin
                    if (rx_enable && !rx_sync)
                    begin
                        rx_state <= RX_FRAME;
                        rx_baud  <= uart_resp_pkg::HALF_CNT;
                        rx_idx   <= 4'h0;
                    end
                end
                RX_FRAME:
                begin
                    if (rx_false || rx_last_bit)
                    begin
                        rx_state <= RX_IDLE;
                    end
                    else if (rx_tick)
                    begin
                        rx_baud <= uart_resp_pkg::BIT_CNT;
                        rx_idx  <= rx_idx + 4'h1;
                    end
                    else
                    begin
                        rx_baud <= rx_baud - 12'h001;
                    end
                    if (rx_tick && (rx_idx >= 4'h1) && (rx_idx <= 4'h8))
                    begin
                        rx_shift <= {rx_sync, rx_shift[7:1]};
                    end
                    if (rx_tick && (rx_idx == 4'h9))
                    begin
                        rx_par_bit <= rx_sync;
                    end
                    if (rx_last_bit)
                    begin
                        rx_par_bad  <= ^{rx_shift, rx_par_bit};
                        rx_stop_bad <= !rx_sync;
                    end
                end
                default:
                begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Event decode for a completed frame.
    wire ring_full      = ring_fill_count == uart_resp_pkg::RING_FULL;
    wire ring_empty     = ring_fill_count == 8'h00;
    wire overrun_err    = rx_end && hold_valid;
    wire framing_err    = rx_end && rx_stop_bad;
    wire parity_err     = rx_end && rx_par_bad;
    wire rx_error_event = overrun_err || framing_err || parity_err;
    wire rx_done_event  = rx_end && !rx_error_event;

    // At most one entry per character (none for an errored one while the ring is full), the most serious error named.
    wire [2:0] error_code = overrun_err ? uart_resp_pkg::CODE_OVERRUN :
                            framing_err ? uart_resp_pkg::CODE_FRAMING :
                            uart_resp_pkg::CODE_PARITY;

    // A held character is taken once space opens and no frame event competes.
    wire take_hold   = hold_valid && !rx_end && !ring_full;
    wire store_error = rx_error_event && !ring_full;
    wire store_char  = rx_done_event && !ring_full;
    wire store       = store_error || store_char || take_hold;
    wire [2:0] store_code = store_error ? error_code :
                            store_char  ? classify(rx_shift) :
                            classify(hold_data);

    // Receive and error events come first; a waiting transmit done is serviced after.
    wire tx_service = tx_pending && !rx_end;
    wire take       = (tx_state == TX_IDLE) && !ring_empty && tx_enable;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hold_valid <= 1'b0;
            hold_data  <= 8'h00;
            last_char  <= 8'h00;
        end
        else
        begin
            if (rx_done_event && ring_full)
            begin
                hold_valid <= 1'b1;
                hold_data  <= rx_shift;
            end
            else if (take_hold || store_char)
            begin
                hold_valid <= 1'b0;
            end
            if (rx_done_event)
            begin
                last_char <= rx_shift;
            end
        end
    end

    generate
        for (genvar slot = 0; slot < RING_SLOTS; slot++)
        begin : g_ring
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    reply_ring[slot] <= uart_resp_pkg::CODE_OTHER;
                end
                else if (store && (ring_write_ptr[3:0] == 4'(slot)))
                begin
                    reply_ring[slot] <= store_code;
                end
            end
        end
    endgenerate

    wire [7:0] next_fill = ring_fill_count + {7'h00, store} - {7'h00, take};

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ring_write_ptr  <= 8'h00;
            ring_read_ptr   <= 8'h00;
            ring_fill_count <= 8'h00;
        end
        else
        begin
            if (store)
            begin
                ring_write_ptr <= ring_write_ptr + 8'h01;
            end
            if (take)
            begin
                ring_read_ptr <= ring_read_ptr + 8'h01;
            end
            ring_fill_count <= next_fill;
        end
    end

    wire [2:0] next_remaining = tx_remaining_count - 3'h1;
    wire [1:0] byte_idx       = 2'(uart_resp_pkg::REPLY_LEN - tx_remaining_count);

    // Reply sequencer; reception keeps running underneath it.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_state           <= TX_IDLE;
            tx_code            <= uart_resp_pkg::CODE_OTHER;
            tx_remaining_count <= 3'h0;
            tx_pending         <= 1'b0;
            ser_start          <= 1'b0;
            ser_data           <= 8'h00;
        end
        else
        begin
            ser_start <= 1'b0;
            if (tx_done_event)
            begin
                tx_pending <= 1'b1;
            end
            else if (tx_service)
            begin
                tx_pending <= 1'b0;
            end
            case (tx_state)
                TX_IDLE:
                begin
                    if (take)
                    begin
                        tx_code            <= reply_ring[ring_read_ptr[3:0]];
                        tx_remaining_count <= uart_resp_pkg::REPLY_LEN;
                        tx_state           <= TX_SEND;
                    end
                end
                TX_SEND:
                begin
                    ser_data  <= reply_byte(tx_code, byte_idx);
                    ser_start <= 1'b1;
                    tx_state  <= TX_WAIT;
                end
                TX_WAIT:
                begin
                    if (tx_service)
                    begin
                        tx_remaining_count <= next_remaining;
                        tx_state <= (next_remaining != 3'h0) ? TX_SEND : TX_IDLE;
                    end
                end
                default:
                begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    uart_tx_serializer u_tx (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .start      (ser_start),
        .data       (ser_data),
        .serial_out (serial_out),
        .busy       (ser_busy),
        .done       (tx_done_event)
    );

    // Register bus: every access is answered on the second edge it is seen.
    wire        bus_req   = avs_read || avs_write;
    wire        sel_ctrl  = avs_address == uart_resp_pkg::REG_CONTROL;
    wire        sel_stat  = avs_address == uart_resp_pkg::REG_STATUS;
    wire        sel_ptrs  = avs_address == uart_resp_pkg::REG_POINTERS;
    wire        sel_last  = avs_address == uart_resp_pkg::REG_LAST;
    wire        ctrl_wr   = avs_write && bus_ack && sel_ctrl && avs_byteenable[0];
    wire [31:0] stat_word = {12'h000, hold_valid, ser_busy, ring_full, ring_empty,
                             5'h00, tx_remaining_count, ring_fill_count};
    wire [31:0] ptr_word  = {16'h0000, ring_read_ptr, ring_write_ptr};
    wire [31:0] read_word = sel_ctrl ? {30'h00000000, control} :
                            sel_stat ? stat_word :
                            sel_ptrs ? ptr_word :
                            sel_last ? {24'h000000, last_char} :
                            32'h00000000;

    assign avs_waitrequest = bus_req && !bus_ack;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_ack      <= 1'b0;
            avs_readdata <= 32'h00000000;
            control      <= uart_resp_pkg::CONTROL_RST;
        end
        else
        begin
            bus_ack <= bus_req && !bus_ack;
            if (avs_read && !bus_ack)
            begin
                avs_readdata <= read_word;
            end
            if (ctrl_wr)
            begin
                control <= avs_writedata[1:0];
            end
        end
    end

endmodule

// ### sim/uart_char_responder_chk.sv
`timescale 1ns/1ns
module uart_char_responder_chk (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        serial_in,
    input wire logic        serial_out
);
    logic        prev_out;
    int unsigned run_len;
    logic        st_rd;
    logic        bad_addr;
    assign st_rd = avs_read && !avs_waitrequest && avs_address == uart_resp_pkg::REG_STATUS;
    assign bad_addr = avs_address[1:0] != 2'h0;
    // Counts how long the line has kept its level; a bit slip shows as a run length that is not a whole multiple of BIT_CYCLES.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prev_out <= 1'b1;
            run_len <= 0;
        end
        else
        begin
            prev_out <= serial_out;
            run_len <= (serial_out != prev_out) ? 1 : run_len + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    chk_one_wait_state: assert property (($rose(avs_read) || $rose(avs_write)) |-> one_wait)
        else $error("wait state count wrong");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && bad_addr |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_flags: assert property (st_rd |-> avs_readdata[16] == (avs_readdata[7:0] == 8'h0) &&
        avs_readdata[17] == (avs_readdata[7:0] == uart_resp_pkg::RING_FULL)) else $error("ring flags wrong");
    chk_fill_bound: assert property (st_rd |-> avs_readdata[7:0] <= uart_resp_pkg::RING_FULL)
        else $error("fill count too large");
    chk_idle_reset: assert property ($fell(sys_rst) |-> serial_out [*8])
        else $error("line not idle after reset");
    chk_low_run_bits: assert property ($rose(serial_out) |-> run_len % uart_resp_pkg::BIT_CYCLES == 0)
        else $error("low run not whole bits");
    chk_low_run_max: assert property (!serial_out && !prev_out |-> run_len <= 10 * uart_resp_pkg::BIT_CYCLES)
        else $error("low run too long");
    chk_stop_length: assert property ($fell(serial_out) |-> run_len >= uart_resp_pkg::BIT_CYCLES)
        else $error("stop bit too short");
endmodule
bind uart_char_responder uart_char_responder_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_in(serial_in), .serial_out(serial_out));

// ### sim/uart_remote_station.sv
`timescale 1ns/1ns
module uart_remote_station (
    input  wire logic clk_sys,
    output logic      serial_in,
    input  wire logic serial_out
);
    localparam int BIT = int'(uart_resp_pkg::BIT_CYCLES);
    initial serial_in = 1'b1;
    // A bad stop bit is held low only past mid bit, so the line is high again before any false start is sampled.
    task automatic send_char(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
    begin
        f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            serial_in <= f[i];
            repeat ((i == 10 && bad_stop) ? BIT / 2 + 200 : BIT) @(posedge clk_sys);
        end
        serial_in <= 1'b1;
        @(posedge clk_sys);
    end
    endtask
    task automatic get_char(output logic [7:0] d, output logic p, output logic s, output logic ok);
        int n;
    begin
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (serial_out !== 1'b0 && n < 5000);
        ok = serial_out === 1'b0;
        repeat (BIT / 2) @(negedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(negedge clk_sys);
            d[i] = serial_out;
        end
        repeat (BIT) @(negedge clk_sys);
        p = serial_out;
        repeat (BIT) @(negedge clk_sys);
        s = serial_out;
    end
    endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic        clk_sys;
    logic        sys_rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        serial_in;
    logic        serial_out;
    int          err_count;
    int          n_compared;
    uart_char_responder dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_in(serial_in), .serial_out(serial_out));
    uart_remote_station station (.clk_sys(clk_sys), .serial_in(serial_in), .serial_out(serial_out));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic final_report();
    begin
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int   n;
        logic w;
    begin
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= we;
        avs_read <= !we;
        do
        begin
            @(negedge clk_sys);
            w = avs_waitrequest;
            rd = avs_readdata;
            @(posedge clk_sys);
            n++;
        end
        while (w !== 1'b0 && n < 20);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
        if (w !== 1'b0)
        begin
            err_count++;
            final_report();
        end
    end
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
    begin
        bus(1'b0, a, 32'h0, d);
        `CHK(nm, exp, d & mask)
    end
    endtask
    task automatic test_reset_regs();
    begin
        rd_chk("control", uart_resp_pkg::REG_CONTROL, 32'hffffffff, 32'h00000003);
        rd_chk("status", uart_resp_pkg::REG_STATUS, 32'hffffffff, 32'h00010000);
        rd_chk("pointers", uart_resp_pkg::REG_POINTERS, 32'hffffffff, 32'h00000000);
        rd_chk("unmapped", 4'h2, 32'hffffffff, 32'h00000000);
    end
    endtask
    // Replies are held back so three receptions pile up in the ring without transmit traffic.
    task automatic test_queue_held();
        logic [31:0] d;
    begin
        bus(1'b1, uart_resp_pkg::REG_CONTROL, 32'h00000001, d);
        station.send_char(8'h74, 1'b0, 1'b0);
        station.send_char(8'h41, 1'b1, 1'b0);
        station.send_char(8'h55, 1'b0, 1'b1);
        repeat (20) @(posedge clk_sys);
        rd_chk("fill count", uart_resp_pkg::REG_STATUS, 32'h000f00ff, 32'h00000003);
        rd_chk("write pointer", uart_resp_pkg::REG_POINTERS, 32'h0000ffff, 32'h00000003);
        rd_chk("last clean", uart_resp_pkg::REG_LAST, 32'h000000ff, 32'h00000074);
    end
    endtask
    task automatic test_reply_out();
        logic [7:0]  d;
        logic        p;
        logic        s;
        logic        ok;
        logic [31:0] r;
    begin
        bus(1'b1, uart_resp_pkg::REG_CONTROL, 32'h00000003, r);
        station.get_char(d, p, s, ok);
        `CHK("reply start", 1'b1, ok)
        `CHK("first byte", uart_resp_pkg::BYTE_LOWER_O, d)
        `CHK("parity", ^uart_resp_pkg::BYTE_LOWER_O, p)
        `CHK("stop", 1'b1, s)
        @(posedge clk_sys);
        rd_chk("read pointer", uart_resp_pkg::REG_POINTERS, 32'h0000ffff, 32'h00000103);
        rd_chk("fill busy", uart_resp_pkg::REG_STATUS, 32'h000f07ff, 32'h00040402);
    end
    endtask
    initial
    begin
        err_count = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        test_reset_regs();
        test_queue_held();
        test_reply_out();
        final_report();
    end
    initial
    begin
        repeat (99000) @(posedge clk_sys);
        err_count++;
        final_report();
    end
endmodule
